/* File: core/brls_pkg.sv */
// Package of constants and types for the boot and reset sequencer.
package brls_pkg;
   // Clock rate and derived timing.
   localparam int unsigned CLK_HZ            = 50_000_000;
   localparam int unsigned SKIP_HOLD_US      = 1000;
   localparam int unsigned SKIP_HOLD_CYC     = (SKIP_HOLD_US * (CLK_HZ / 1_000_000));
   localparam int unsigned I2C_HALF_NS       = 2500;
   localparam int unsigned I2C_HALF_CYC      = (I2C_HALF_NS + 19) / 20;
   // Memory sizes to clear.
   localparam logic [15:0] MCU_IRAM_SIZE     = 16'h0100;
   localparam logic [15:0] MCU_XRAM_SIZE     = 16'h0800;
   localparam logic [15:0] MCU_PRAM_SIZE     = 16'h4000;
   localparam logic [15:0] DSP_PRAM_SIZE     = 16'h0d00;
   localparam logic [15:0] DSP_COEF_SIZE     = 16'h0400;
   localparam logic [15:0] DSP_DRAM_SIZE     = 16'h0300;
   // Memory select codes.
   localparam logic [1:0]  MSEL_MCU_PRAM     = 2'h2;
   localparam logic [1:0]  MSEL_DSP_PRAM     = 2'h1;
   localparam logic [1:0]  MSEL_DSP_DATA     = 2'h0;
   // Default hardware settings.
   localparam logic [7:0]  EXT_FUNC_ADDR     = 8'hc0;
   localparam int unsigned DLY_FLUSH_BIT     = 3;
   localparam logic [7:0]  FETCH_SRC_ADDR    = 8'hfd;
   localparam logic [7:0]  CLK_SETUP_DEF     = 8'h0a;
   localparam logic [7:0]  CLK_SKEW_DEF      = 8'h05;
   localparam logic [7:0]  CLK_DLY_SEL_DEF   = 8'h80;
   localparam logic [7:0]  SAP_WORD_DEF      = 8'h22;
   localparam logic [7:0]  SAP_MODE_DEF      = 8'h22;
   // Two-wire addresses (serial memory in 8-bit write form, slave in 7 bits) and load framing.
   localparam logic [7:0]  EEPROM_ADDR_CS0   = 8'ha0;
   localparam logic [7:0]  EEPROM_ADDR_CS1   = 8'ha2;
   localparam logic [6:0]  SLAVE_ADDR_CS0    = 7'h34;
   localparam logic [6:0]  SLAVE_ADDR_CS1    = 7'h35;
   localparam logic [7:0]  EOP_HEADER        = 8'hff;
   localparam logic [7:0]  MAX_BLOCK_BYTES   = 8'hff;
   // Load result codes.
   localparam logic [1:0]  RES_NONE          = 2'h0;
   localparam logic [1:0]  RES_EEPROM_OK     = 2'h1;
   localparam logic [1:0]  RES_NO_EEPROM     = 2'h2;
   localparam logic [1:0]  RES_READ_ERROR    = 2'h3;

   typedef enum {
      ST_RESET, ST_CLR_IRAM, ST_CLR_XRAM, ST_DLY_FLUSH, ST_DEFAULTS, ST_CLR_MPRAM,
      ST_CLR_DPRAM, ST_CLR_COEF, ST_CLR_DRAM, ST_SKIP_CHECK, ST_MASTER_EN, ST_LOAD,
      ST_SLAVE_SW, ST_FETCH_SW, ST_DSP_START, ST_STATUS_PIN, ST_DONE
   } brls_state_t;

   typedef enum {
      TW_IDLE, TW_START, TW_BIT, TW_ACK, TW_RSTART, TW_STOP
   } brls_tw_t;

   // Clear count for a given memory select code.
   function automatic logic [15:0] brls_words(input logic [1:0] sel);
      if (sel == MSEL_MCU_PRAM) begin
         return MCU_PRAM_SIZE;
      end else if (sel == MSEL_DSP_PRAM) begin
         return DSP_PRAM_SIZE;
      end else begin
         return DSP_COEF_SIZE;
      end
   endfunction
endpackage

/* File: core/brls_boot_sequencer.sv */
// Boot and reset sequencer: memory clearing, defaults, serial memory load and hand-over to slave mode.
`timescale 1ns/100ps
module brls_boot_sequencer
   import brls_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire logic        chip_select,
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic        boot_status_pin_in,
   output logic             boot_status_pin_out,
   output logic             boot_status_pin_oe,
   output logic             mem_clr_we,
   output logic [1:0]       mem_clr_space,
   output logic [15:0]      mem_clr_addr,
   output logic [1:0]       mem_select,
   output logic             mem_wr,
   output logic [15:0]      mem_wr_addr,
   output logic [7:0]       mem_wr_data,
   output logic             esfr_we,
   output logic [7:0]       esfr_addr,
   output logic [7:0]       esfr_data,
   output logic [7:0]       clock_setup_primary,
   output logic [7:0]       clock_skew_setup,
   output logic [7:0]       clock_delay_select,
   output logic [7:0]       sap_word_length,
   output logic [7:0]       sap_format,
   output logic             sap_enable,
   output logic             master_enable,
   output logic             slave_enable,
   output logic             bus_role_select,
   output logic [6:0]       slave_address,
   output logic             fetch_origin_select,
   output logic             mcu_pc_reset,
   output logic             dsp_halt,
   output logic             audio_passthrough,
   output logic [1:0]       load_result,
   output logic             boot_done
);
   brls_state_t st_reg;
   brls_tw_t    tw_reg;
   logic [2:0]  scl_sync_reg, sda_sync_reg, gp_sync_reg;
   logic [15:0] cnt_reg;
   logic [16:0] skip_cnt_reg;
   logic        skip_seen_reg;
   logic        gp_sample_reg;
   logic [7:0]  half_reg;
   logic        tick;
   logic [3:0]  bit_reg;
   logic [8:0]  sh_reg;
   logic [3:0]  phase_reg;
   logic [7:0]  blk_len_reg;
   logic [15:0] blk_addr_reg;
   logic        nack_reg, rx_reg, setup_reg;
   logic [7:0]  rx_byte_reg;

   // Three-flop synchronisers on pins; only stage [1] and later feed logic.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         scl_sync_reg <= 3'h7;
         sda_sync_reg <= 3'h7;
         gp_sync_reg  <= 3'h0;
      end else begin
         scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
         sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
         gp_sync_reg  <= {gp_sync_reg[1:0], boot_status_pin_in};
      end
   end

   // Both-lines-low detector; the count restarts whenever either line reads high, until the hold is seen.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         skip_cnt_reg  <= 17'h0;
         skip_seen_reg <= 1'b0;
      end else if (!scl_sync_reg[1] && !sda_sync_reg[1] && !master_enable) begin
         if (skip_cnt_reg == 17'(SKIP_HOLD_CYC - 1)) begin
            skip_seen_reg <= 1'b1;
         end else begin
            skip_cnt_reg <= skip_cnt_reg + 17'h1;
         end
      end else if (!skip_seen_reg) begin
         skip_cnt_reg <= 17'h0;
      end
   end

   // Bit-rate enable for the master engine; a one-cycle pulse every I2C_HALF_CYC clocks.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         half_reg <= 8'h0;
         tick     <= 1'b0;
      end else begin
         tick     <= (half_reg == 8'(I2C_HALF_CYC - 1));
         half_reg <= (half_reg == 8'(I2C_HALF_CYC - 1)) ? 8'h0 : half_reg + 8'h1;
      end
   end

   // Main boot sequence. Each step advances only when its own work is done.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st_reg              <= ST_RESET;
         cnt_reg             <= 16'h0;
         mem_clr_we          <= 1'b0;
         mem_clr_space       <= 2'h0;
         mem_clr_addr        <= 16'h0;
         mem_select          <= MSEL_DSP_DATA;
         esfr_we             <= 1'b0;
         esfr_addr           <= 8'h0;
         esfr_data           <= 8'h0;
         clock_setup_primary <= 8'h0;
         clock_skew_setup    <= 8'h0;
         clock_delay_select  <= 8'h0;
         sap_word_length     <= 8'h0;
         sap_format          <= 8'h0;
         sap_enable          <= 1'b0;
         master_enable       <= 1'b0;
         slave_enable        <= 1'b0;
         bus_role_select     <= 1'b0;
         slave_address       <= SLAVE_ADDR_CS0;
         fetch_origin_select <= 1'b0;
         mcu_pc_reset        <= 1'b0;
         dsp_halt            <= 1'b1;
         audio_passthrough   <= 1'b0;
         load_result         <= RES_NONE;
         boot_done           <= 1'b0;
         boot_status_pin_out <= 1'b0;
         boot_status_pin_oe  <= 1'b0;
         gp_sample_reg       <= 1'b0;
      end else begin
         esfr_we      <= 1'b0;
         mcu_pc_reset <= 1'b0;
         case (st_reg)
            ST_RESET: begin
               st_reg <= ST_CLR_IRAM;
               cnt_reg <= 16'h0;
            end
            ST_CLR_IRAM, ST_CLR_XRAM, ST_CLR_MPRAM, ST_CLR_DPRAM, ST_CLR_COEF, ST_CLR_DRAM: begin
               mem_clr_we   <= 1'b1;
               mem_clr_addr <= cnt_reg;
               case (st_reg)
                  ST_CLR_IRAM:  mem_clr_space <= 2'h0;
                  ST_CLR_XRAM:  mem_clr_space <= 2'h1;
                  default:      mem_clr_space <= 2'h2;
               endcase
               // The select code travels with each stroke, so no stroke is shown under the next memory's code.
               mem_select <= (st_reg == ST_CLR_MPRAM) ? MSEL_MCU_PRAM :
                             (st_reg == ST_CLR_DPRAM) ? MSEL_DSP_PRAM : MSEL_DSP_DATA;
               cnt_reg <= cnt_reg + 16'h1;
               if ((st_reg == ST_CLR_IRAM  && cnt_reg == MCU_IRAM_SIZE - 16'h1) ||
                   (st_reg == ST_CLR_XRAM  && cnt_reg == MCU_XRAM_SIZE - 16'h1) ||
                   (st_reg == ST_CLR_MPRAM && cnt_reg == brls_words(MSEL_MCU_PRAM) - 16'h1) ||
                   (st_reg == ST_CLR_DPRAM && cnt_reg == brls_words(MSEL_DSP_PRAM) - 16'h1) ||
                   (st_reg == ST_CLR_COEF  && cnt_reg == brls_words(MSEL_DSP_DATA) - 16'h1) ||
                   (st_reg == ST_CLR_DRAM  && cnt_reg == DSP_DRAM_SIZE - 16'h1)) begin
                  cnt_reg <= 16'h0;
                  case (st_reg)
                     ST_CLR_IRAM:  st_reg <= ST_CLR_XRAM;
                     ST_CLR_XRAM:  st_reg <= ST_DLY_FLUSH;
                     ST_CLR_MPRAM: st_reg <= ST_CLR_DPRAM;
                     ST_CLR_DPRAM: st_reg <= ST_CLR_COEF;
                     ST_CLR_COEF:  st_reg <= ST_CLR_DRAM;
                     default:      st_reg <= ST_SKIP_CHECK;
                  endcase
               end
            end
            ST_DLY_FLUSH: begin
               mem_clr_we <= 1'b0;
               esfr_we    <= 1'b1;
               esfr_addr  <= EXT_FUNC_ADDR;
               esfr_data  <= 8'(1 << DLY_FLUSH_BIT);
               st_reg     <= ST_DEFAULTS;
            end
            ST_DEFAULTS: begin
               clock_setup_primary <= CLK_SETUP_DEF;
               clock_skew_setup    <= CLK_SKEW_DEF;
               clock_delay_select  <= CLK_DLY_SEL_DEF;
               sap_word_length     <= SAP_WORD_DEF;
               sap_format          <= SAP_MODE_DEF;
               sap_enable          <= 1'b1;
               mem_select          <= MSEL_MCU_PRAM;
               st_reg              <= ST_CLR_MPRAM;
            end
            ST_SKIP_CHECK: begin
               mem_clr_we <= 1'b0;
               if (skip_seen_reg) begin
                  load_result <= RES_NO_EEPROM;
                  st_reg      <= ST_SLAVE_SW;
               end else if (skip_cnt_reg == 17'h0) begin
                  st_reg <= ST_MASTER_EN;
               end
            end
            ST_MASTER_EN: begin
               slave_enable    <= 1'b0;
               master_enable   <= 1'b1;
               bus_role_select <= 1'b1;
               st_reg          <= ST_LOAD;
            end
            ST_LOAD: begin
               if (phase_reg == 4'hf) begin
                  load_result <= nack_reg ? (blk_addr_reg == 16'h0 ? RES_NO_EEPROM : RES_READ_ERROR)
                                          : RES_EEPROM_OK;
                  st_reg      <= ST_SLAVE_SW;
               end
            end
            ST_SLAVE_SW: begin
               master_enable   <= 1'b0;
               bus_role_select <= 1'b0;
               slave_enable    <= 1'b1;
               slave_address   <= chip_select ? SLAVE_ADDR_CS1 : SLAVE_ADDR_CS0;
               st_reg          <= ST_FETCH_SW;
            end
            ST_FETCH_SW: begin
               fetch_origin_select <= 1'b1;
               esfr_we             <= 1'b1;
               esfr_addr           <= FETCH_SRC_ADDR;
               esfr_data           <= 8'h01;
               mcu_pc_reset        <= (load_result == RES_EEPROM_OK);
               gp_sample_reg       <= gp_sync_reg[2];
               st_reg              <= ST_DSP_START;
            end
            ST_DSP_START: begin
               dsp_halt <= gp_sample_reg;
               audio_passthrough <= (load_result != RES_EEPROM_OK) && !gp_sample_reg;
               st_reg   <= ST_STATUS_PIN;
            end
            ST_STATUS_PIN: begin
               boot_status_pin_out <= 1'b0;
               boot_status_pin_oe  <= 1'b1;
               boot_done           <= 1'b1;
               st_reg              <= ST_DONE;
            end
            default: begin
               st_reg <= ST_DONE;
            end
         endcase
      end
   end

   // Master engine: phase 0 write address, 1..2 zero pointer, repeated start, 3 read address, 4+ bytes, f done.
   // A deliberately small reader: one header byte gives a block length, 8'hff ends the load.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tw_reg <= TW_IDLE; phase_reg <= 4'h0; bit_reg <= 4'h0; sh_reg <= 9'h1ff;
         scl_out <= 1'b1; scl_oe <= 1'b0; sda_out <= 1'b1; sda_oe <= 1'b0;
         nack_reg <= 1'b0; rx_reg <= 1'b0; rx_byte_reg <= 8'h0; setup_reg <= 1'b0;
         blk_len_reg <= 8'h0; blk_addr_reg <= 16'h0;
         mem_wr <= 1'b0; mem_wr_addr <= 16'h0; mem_wr_data <= 8'h0;
      end else begin
         mem_wr <= 1'b0;
         if (st_reg == ST_LOAD && tick && phase_reg != 4'hf) begin
            case (tw_reg)
               TW_IDLE: begin
                  sda_oe <= 1'b1; sda_out <= 1'b0; tw_reg <= TW_START; // Start condition.
                  sh_reg <= {(chip_select ? EEPROM_ADDR_CS1 : EEPROM_ADDR_CS0), 1'b1};
               end
               TW_START: begin
                  scl_oe <= 1'b1; scl_out <= 1'b0; bit_reg <= 4'h0; setup_reg <= 1'b0; tw_reg <= TW_BIT;
               end
               TW_RSTART: begin // Three steps, so data never moves while the clock rises.
                  bit_reg <= bit_reg + 4'h1;
                  if (bit_reg == 4'h0) sda_oe <= 1'b0;
                  else if (bit_reg == 4'h1) {scl_oe, scl_out} <= 2'b01;
                  else begin
                     sda_oe <= 1'b1; tw_reg <= TW_START;
                     sh_reg <= {(chip_select ? EEPROM_ADDR_CS1 : EEPROM_ADDR_CS0) | 8'h01, 1'b1};
                  end
               end
               TW_BIT: begin
                  if (scl_out == 1'b0 && !setup_reg) begin
                     sda_oe <= rx_reg ? 1'b0 : !sh_reg[8]; setup_reg <= 1'b1;
                  end else if (scl_out == 1'b0) begin
                     scl_oe <= 1'b0; scl_out <= 1'b1; setup_reg <= 1'b0;
                  end else begin
                     rx_byte_reg <= {rx_byte_reg[6:0], sda_sync_reg[2]};
                     sh_reg <= {sh_reg[7:0], 1'b1};
                     scl_oe <= 1'b1; scl_out <= 1'b0;
                     bit_reg <= bit_reg + 4'h1;
                     if (bit_reg == 4'h7) begin
                        tw_reg <= TW_ACK;
                     end
                  end
               end
               TW_ACK: begin
                  if (scl_out == 1'b0 && !setup_reg) begin
                     sda_oe <= rx_reg; setup_reg <= 1'b1; // Master acks read bytes.
                  end else if (scl_out == 1'b0) begin
                     scl_oe <= 1'b0; scl_out <= 1'b1; setup_reg <= 1'b0;
                  end else begin
                     scl_oe <= 1'b1; scl_out <= 1'b0; bit_reg <= 4'h0;
                     if (!rx_reg && sda_sync_reg[2]) begin
                        nack_reg <= 1'b1; tw_reg <= TW_STOP;
                     end else if (!rx_reg) begin
                        rx_reg <= (phase_reg == 4'h3);
                        phase_reg <= phase_reg + 4'h1;
                        sh_reg <= 9'h001;
                        tw_reg <= (phase_reg == 4'h2) ? TW_RSTART : TW_BIT;
                     end else if (blk_len_reg == 8'h0 && rx_byte_reg == EOP_HEADER) begin
                        tw_reg <= TW_STOP;
                     end else if (blk_len_reg == 8'h0) begin
                        blk_len_reg <= rx_byte_reg; tw_reg <= TW_BIT;
                     end else begin
                        mem_wr <= 1'b1; mem_wr_addr <= blk_addr_reg; mem_wr_data <= rx_byte_reg;
                        blk_addr_reg <= blk_addr_reg + 16'h1;
                        blk_len_reg <= blk_len_reg - 8'h1; tw_reg <= TW_BIT;
                     end
                  end
               end
               default: begin // Data low, then clock up, then data up: never a false start.
                  bit_reg <= bit_reg + 4'h1;
                  if (bit_reg == 4'h0) {sda_oe, sda_out} <= 2'b10;
                  else if (bit_reg == 4'h1) {scl_oe, scl_out} <= 2'b01;
                  else begin
                     sda_oe <= 1'b0; sda_out <= 1'b1; phase_reg <= 4'hf; // Stop, lines released.
                  end
               end
            endcase
         end
      end
   end
endmodule

/* File: sim/brls_boot_properties.sv */
// Concurrent checks on the ports of the boot sequencer.
`timescale 1ns/100ps
module brls_boot_properties (
   input wire logic        clk_sys,
   input wire logic        resetn,
   input wire logic        chip_select,
   input wire logic        scl_oe,
   input wire logic        sda_oe,
   input wire logic        boot_status_pin_out,
   input wire logic        boot_status_pin_oe,
   input wire logic        mem_clr_we,
   input wire logic [1:0]  mem_clr_space,
   input wire logic [15:0] mem_clr_addr,
   input wire logic [1:0]  mem_select,
   input wire logic        esfr_we,
   input wire logic [7:0]  esfr_addr,
   input wire logic [7:0]  esfr_data,
   input wire logic [7:0]  clock_setup_primary,
   input wire logic [7:0]  clock_skew_setup,
   input wire logic [7:0]  clock_delay_select,
   input wire logic        sap_enable,
   input wire logic        master_enable,
   input wire logic        slave_enable,
   input wire logic        bus_role_select,
   input wire logic [6:0]  slave_address,
   input wire logic        fetch_origin_select,
   input wire logic        dsp_halt,
   input wire logic [1:0]  load_result,
   input wire logic        boot_done
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   // Reset values are checked at the first edge after release, before the sequence moves.
   AST_RESET_STATE: assert property ($rose(resetn) |-> !scl_oe && !sda_oe && dsp_halt && !boot_done)
      else $error("outputs not at reset values after release");
   AST_LINES_QUIET: assert property (!master_enable && !slave_enable |-> !scl_oe && !sda_oe)
      else $error("two-wire line driven while no interface is enabled");
   AST_FLUSH_WRITE: assert property (esfr_we && esfr_addr == 8'hc0 |-> esfr_data[3] && !master_enable)
      else $error("delay flush write wrong or late");
   AST_MASTER_AFTER_DEFAULTS: assert property ($rose(master_enable) |-> clock_setup_primary == 8'h0a
      && clock_skew_setup == 8'h05 && clock_delay_select == 8'h80 && sap_enable && !boot_done)
      else $error("master enabled before defaults were loaded");
   // A clear stroke in space 2 must stay inside the memory that the select code names.
   AST_CLEAR_BOUND: assert property (mem_clr_we && mem_clr_space == 2'h2 |->
      (mem_select == 2'h2 && mem_clr_addr < 16'h4000) || (mem_select == 2'h1 && mem_clr_addr < 16'h0d00)
      || (mem_select == 2'h0 && mem_clr_addr < 16'h0400))
      else $error("clear address outside the selected memory");
   AST_NO_DUAL_ROLE: assert property (!(master_enable && slave_enable))
      else $error("master and slave enabled together");
   AST_SLAVE_HANDOVER: assert property ($fell(master_enable) |-> ##[0:8] slave_enable)
      else $error("slave not enabled after master was dropped");
   AST_ROLE_CLEARED: assert property (slave_enable |-> bus_role_select == 1'b0)
      else $error("role select not cleared in slave mode");
   AST_SLAVE_ADDRESS: assert property (slave_enable |-> slave_address == (chip_select ? 7'h35 : 7'h34))
      else $error("slave address does not follow chip select");
   AST_FETCH_SWITCH: assert property (esfr_we && esfr_addr == 8'hfd |-> esfr_data == 8'h01 ##[0:4] fetch_origin_select)
      else $error("fetch origin not switched to RAM");
   AST_STATUS_LAST: assert property ($rose(boot_status_pin_oe) |-> !boot_status_pin_out
      && fetch_origin_select && slave_enable && load_result != 2'h0)
      else $error("status pin released before the boot finished");

   COV_MASTER_ON: cover property ($rose(master_enable));
   COV_LOAD_OK: cover property (boot_done && load_result == 2'h1);
   COV_NO_MEMORY: cover property (boot_done && load_result == 2'h2);
endmodule

/* File: sim/brls_eeprom_model.sv */
// Behavioural two-wire serial memory holding one data block and an end header.
`timescale 1ns/100ps
module brls_eeprom_model (
   input wire logic        scl,
   input wire logic        sda,
   input wire logic        present,
   input wire logic        cs,
   input wire logic        rst,
   output logic            pull_low,
   output logic [7:0]      first_addr
);
   logic [7:0]  rom [0:7];
   logic [7:0]  sh;
   logic [15:0] ptr;
   logic [3:0]  cnt;
   logic [1:0]  st;
   logic        rw;

   // States: 0 idle, 1 address, 2 write, 3 read. Past the image the memory reads end headers until the index wraps after entry 7.
   initial begin
      rom = '{8'h03, 8'ha5, 8'h5a, 8'h3c, 8'hff, 8'hff, 8'hff, 8'hff};
      {pull_low, st, cnt, ptr, sh, rw, first_addr} = '0;
   end
   always @(posedge rst) {ptr, first_addr, st, pull_low} = '0;

   // Start and stop are data edges while the clock is high; either drops the transfer.
   always @(negedge sda) if (scl) {st, cnt, pull_low} = {2'd1, 4'd0, 1'b0};
   always @(posedge sda) if (scl) {st, pull_low} = 3'b000;

   always @(posedge scl) begin
      if (st != 2'd0 && cnt < 4'd8) begin
         if (st != 2'd3) sh = {sh[6:0], sda};
         cnt = cnt + 4'd1;
      end else if (st == 2'd3 && cnt == 4'd8) begin
         // A missing acknowledge from the master ends the read.
         if (sda) st = 2'd0;
         else {ptr, cnt} = {ptr + 16'd1, 4'd0};
      end
   end

   // The line is only changed while the clock is low, so no false start is ever made.
   always @(negedge scl) begin
      if (cnt == 4'd9) begin
         {cnt, pull_low} = 5'd0;
         st = (st == 2'd1 && rw) ? 2'd3 : 2'd2;
      end else if (cnt == 4'd8 && st == 2'd1) begin
         if (first_addr == 8'h00) first_addr = sh;
         rw = sh[0];
         cnt = 4'd9;
         pull_low = present && sh[7:1] == {6'b101000, cs};
         if (!pull_low) st = 2'd0;
      end else if (cnt == 4'd8 && st == 2'd2) begin
         ptr = {ptr[7:0], sh};
         {cnt, pull_low} = {4'd9, 1'b1};
      end
      if (st == 2'd3) pull_low = cnt < 4'd8 && !rom[ptr[2:0]][7 - cnt];
   end
endmodule

/* File: sim/tb.sv */
// Self-checking bench: a boot from ROM defaults and a boot from the serial memory.
`timescale 1ns/100ps
module tb;
   import brls_pkg::*;
   logic        clk_sys = 1'b0;
   logic        resetn = 1'b0;
   logic        chip_select = 1'b0;
   logic        present = 1'b0;
   logic        pin_level = 1'b0;
   logic        scl_out, scl_oe, sda_out, sda_oe, boot_status_pin_out, boot_status_pin_oe, ee_pull;
   logic        mem_clr_we, mem_wr, esfr_we, sap_enable, master_enable, slave_enable, bus_role_select;
   logic        fetch_origin_select, mcu_pc_reset, dsp_halt, audio_passthrough, boot_done;
   logic [1:0]  mem_clr_space, mem_select, load_result;
   logic [7:0]  mem_wr_data, esfr_addr, esfr_data, clock_setup_primary, clock_skew_setup, clock_delay_select;
   logic [7:0]  sap_word_length, sap_format, first_addr;
   logic [15:0] mem_clr_addr;
   logic [6:0]  slave_address;
   int          n_fail = 0;
   int          n_tests = 0;
   int          clr_cnt [0:4];
   int          ph, last_ph, order_bad, flush_ph, n_fetch, n_pc;
   logic [7:0]  wr_q [$];
   // Open-drain lines with pull-ups; the status pin follows the design once it drives.
   wire         scl = !(scl_oe && !scl_out);
   wire         sda = !((sda_oe && !sda_out) || ee_pull);
   wire         pin = boot_status_pin_oe ? boot_status_pin_out : pin_level;

   brls_boot_sequencer uut (.clk_sys, .resetn, .chip_select, .scl_in(scl), .scl_out, .scl_oe, .sda_in(sda),
      .sda_out, .sda_oe, .boot_status_pin_in(pin), .boot_status_pin_out, .boot_status_pin_oe, .mem_clr_we,
      .mem_clr_space, .mem_clr_addr, .mem_select, .mem_wr, .mem_wr_addr(), .mem_wr_data, .esfr_we, .esfr_addr,
      .esfr_data, .clock_setup_primary, .clock_skew_setup, .clock_delay_select, .sap_word_length, .sap_format,
      .sap_enable, .master_enable, .slave_enable, .bus_role_select, .slave_address, .fetch_origin_select,
      .mcu_pc_reset, .dsp_halt, .audio_passthrough, .load_result, .boot_done);
   brls_eeprom_model mem_model (.scl(scl), .sda(sda), .present(present), .cs(chip_select), .rst(!resetn),
      .pull_low(ee_pull), .first_addr(first_addr));

   always #10 clk_sys = ~clk_sys;

   // Tally clear strokes per memory, coefficient and data RAM together, and note any step back in the order of memories.
   always @(posedge clk_sys) if (resetn) begin
      if (mem_clr_we) begin
         ph = (mem_clr_space == 2'h2) ? 4 - int'(mem_select) : int'(mem_clr_space);
         if (ph < last_ph) order_bad++;
         last_ph = ph;
         clr_cnt[ph]++;
      end
      if (esfr_we && esfr_addr == 8'hc0 && esfr_data[3]) flush_ph = last_ph;
      if (esfr_we && esfr_addr == 8'hfd && esfr_data == 8'h01) n_fetch++;
      if (mem_wr) wr_q.push_back(mem_wr_data);
      if (mcu_pc_reset) n_pc++;
   end

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // One full boot; the optional early reset lands in mid-clear and must stop it at once.
   task automatic boot(input logic cs, input logic eep, input logic lvl, input logic mid);
      int i;
      // Straps change only under reset, so the running slave never sees its address strap move.
      resetn = 1'b0;
      @(posedge clk_sys);
      #2;
      {chip_select, present, pin_level} = {cs, eep, lvl};
      if (mid) begin
         resetn = 1'b1;
         repeat (300) @(posedge clk_sys);
         #2;
         check(mem_clr_we, 1'b1);
         resetn = 1'b0;
         #1;
         check({mem_clr_we, dsp_halt, master_enable, scl_oe, sda_oe}, 5'b01000);
      end
      resetn = 1'b0;
      repeat (10) @(posedge clk_sys);
      clr_cnt = '{default: 0};
      {last_ph, order_bad, flush_ph, n_fetch, n_pc} = '0;
      wr_q.delete();
      #2 resetn = 1'b1;
      // The host only moves on once the status pin has been driven low.
      for (i = 0; i < 70000 && boot_status_pin_oe !== 1'b1; i++) @(posedge clk_sys);
      if (i == 70000) begin
         n_fail++;
         wrap_up();
      end
      repeat (3) @(posedge clk_sys);
      #2;
      check({clr_cnt[0], clr_cnt[1]}, {32'd256, 32'd2048});
      check(clr_cnt[2], 16384);
      check(clr_cnt[3], 3328);
      check(clr_cnt[4], 1024 + 768);
      check({order_bad, flush_ph}, {32'd0, 32'd1});
      check({clock_setup_primary, clock_skew_setup, clock_delay_select}, 24'h0a0580);
      check({sap_word_length, sap_format, 7'h00, sap_enable}, 24'h222201);
      check(first_addr[7:1], {6'b101000, cs});
      check({master_enable, slave_enable, bus_role_select}, 3'b010);
      check(slave_address, cs ? 7'h35 : 7'h34);
      check({n_fetch, 31'd0, fetch_origin_select}, {32'd1, 32'd1});
      check(dsp_halt, lvl);
      check({boot_status_pin_oe, boot_status_pin_out, pin, boot_done}, 4'b1001);
      if (eep) begin
         check(load_result, 2'h1);
         check(wr_q.size(), 3);
         if (wr_q.size() == 3) check({wr_q[0], wr_q[1], wr_q[2]}, 24'ha55a3c);
         check(n_pc, 1);
      end else begin
         check(load_result, 2'h2);
         check(audio_passthrough, !lvl);
      end
   endtask

   initial begin
      boot(1'b0, 1'b0, 1'b0, 1'b0);
      boot(1'b1, 1'b1, 1'b1, 1'b1);
      wrap_up();
   end
endmodule

bind brls_boot_sequencer brls_boot_properties u_props (.*);
